// file: host_bus_pkg.sv
package host_bus_pkg;

  localparam int ADDR_W = 10;
  localparam int PIN_W  = 16;
  localparam int WORD_W = 32;
  localparam int IDX_W  = 8;

  localparam logic [ADDR_W-1:0] RST_ADDR = 10'h000;
  localparam logic [WORD_W-1:0] RST_WORD = 32'h0000_0000;
  localparam logic [PIN_W-1:0]  RST_PINS = 16'h0000;
  localparam logic [1:0]        OE_OFF   = 2'h3;

  // Pin positions of the select bits carried with the address
  localparam int SP8_BIG   = 10;
  localparam int SP8_FIFO  = 11;
  localparam int SP16_BIG  = 9;
  localparam int SP16_FIFO = 10;
  localparam int DP8_BIG   = 2;
  localparam int DP8_FIFO  = 3;
  localparam int DP16_BIG  = 1;
  localparam int DP16_FIFO = 2;

  localparam logic [2:0] BEATS_8  = 3'h4;
  localparam logic [2:0] BEATS_16 = 3'h2;

  typedef struct packed {
    logic indexed;
    logic bus16;
    logic dual_phase;
    logic en_dir;
    logic cs_high;
    logic rd_high;
    logic wr_high;
    logic lo_high;
    logic hi_high;
    logic cs_qual;
  } host_cfg_t;

  typedef struct packed {
    logic              wr;
    logic              rd_done;
    logic              fifo;
    logic              big;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] wdata;
  } int_req_t;

  typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE} cycle_t;

  // Lowest byte lane touched by one host beat
  function automatic logic [1:0] lane_base(input logic [1:0] off,
                                           input logic w16,
                                           input logic big);
    logic [1:0] rev;
    rev = 2'h3 - off - {1'b0, w16};
    return big ? rev : off;
  endfunction

  function automatic logic [WORD_W-1:0] expand_mask(input logic [3:0] m);
    return {{8{m[3]}}, {8{m[2]}}, {8{m[1]}}, {8{m[0]}}};
  endfunction

endpackage

// file: sync2.sv
`timescale 1ns/10ps
`default_nettype none
module sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);

  logic [W-1:0] meta;

  // No reset: pins flush through while reset is held, so no false edge at release
  // First stage feeds only the second stage
  always_ff @(posedge clk) begin
    meta <= d;
    q    <= meta;
  end

endmodule
`default_nettype wire

// file: byte_lanes.sv
`timescale 1ns/10ps
`default_nettype none
module byte_lanes
  import host_bus_pkg::*;
(
  input  wire logic [1:0]        off,
  input  wire logic              w16,
  input  wire logic              big,
  input  wire logic [PIN_W-1:0]  host_data,
  input  wire logic [WORD_W-1:0] word_in,
  output var  logic [WORD_W-1:0] place_data,
  output var  logic [3:0]        place_mask,
  output var  logic [PIN_W-1:0]  pick_data
);

  wire logic [1:0] base;
  wire logic [7:0] pick_byte;

  assign base = lane_base(off, w16, big);
  assign pick_byte = word_in[{base, 3'h0} +: 8];

  always_comb begin
    place_mask = w16 ? (4'h3 << base) : (4'h1 << base);
    place_data = w16 ? {host_data, host_data} : {4{host_data[7:0]}};
    pick_data  = w16 ? (base[1] ? word_in[31:16] : word_in[15:0])
                     : {8'h00, pick_byte};
  end

endmodule
`default_nettype wire

// file: host_bus_unit.sv
// How it works
// - Config selects multiplexed or indexed addressing
// - Config selects 8-bit or 16-bit data
// - Beats assemble words; reads counted per word
// - Separate strobes or enable plus direction
// - Every control line polarity is configurable
// - Endianness per access, latched or configured
// - FIFO select routes writes TX, reads RX
// - Indexed burst reads toggle low address
// - Single phase 12 pins (11 in 16-bit), dual phase 8
// - Single phase captures all on low strobe
// - 8-bit single phase never drives upper pins
// - Optional chip select qualification of strobes
// - Address held until reset or relatch
// - Dual phase low/high strobes, either order
// - Dual phase upper pins unused or data
// - Registers, FIFOs, memories reached with swapping
// - Byte address 8-bit, word address 16-bit
// - Endian pin above address, FIFO two above
// - Write data on trailing edge, then word write
`timescale 1ns/10ps
`default_nettype none
module host_bus_unit
  import host_bus_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire host_cfg_t         cfg,
  input  wire logic              cs_in,
  input  wire logic              rd_or_dir_in,
  input  wire logic              wr_or_access_enable_in,
  input  wire logic              address_latch_low_strobe,
  input  wire logic              address_latch_high_strobe,
  input  wire logic [PIN_W-1:0]  ad_in,
  input  wire logic [1:0]        low_addr_in,
  input  wire logic              fifo_sel_in,
  input  wire logic              cfg_big_endian,
  input  wire logic [IDX_W-1:0]  index_dword,
  input  wire logic [WORD_W-1:0] rdata,
  output var  logic [PIN_W-1:0]  ad_out,
  output var  logic [1:0]        ad_oe_n,
  output var  logic              read_begin,
  output var  int_req_t          int_req
);

  localparam int SW = $bits(host_cfg_t) + PIN_W + 9;

  // Synchronised pins
  wire logic [SW-1:0] sync_d;
  wire logic [SW-1:0] sync_q;
  host_cfg_t          cs_cfg;
  wire logic          cs_raw;
  wire logic          rd_raw;
  wire logic          wr_raw;
  wire logic          lo_raw;
  wire logic          hi_raw;
  wire logic          fsel_s;
  wire logic          cbig_s;
  wire logic [PIN_W-1:0] ad_s;
  wire logic [1:0]    low_s;

  // Active levels and edges
  wire logic cs_act;
  wire logic rd_lvl;
  wire logic wr_lvl;
  wire logic lo_act;
  wire logic hi_act;
  wire logic rd_cyc;
  wire logic wr_cyc;
  wire logic rd_start;
  wire logic rd_end;
  wire logic wr_end;
  wire logic lo_ok;
  wire logic hi_ok;
  wire logic take_sp;
  wire logic take_dlo;
  wire logic take_dhi;

  logic              cs_prev;
  logic              rd_prev;
  logic              wr_prev;
  logic              lo_prev;
  logic              hi_prev;
  logic [PIN_W-1:0]  ad_prev;

  // Latched address state
  logic [ADDR_W-1:0] addr;
  logic              big;
  logic              fifo;
  wire logic [ADDR_W-1:0] sp_addr;
  wire logic              sp_big;
  wire logic              sp_fifo;
  wire logic [ADDR_W-1:0] lo_addr;
  wire logic [ADDR_W-1:0] dlo_addr;
  wire logic [ADDR_W-1:0] hi_addr;
  wire logic              dp_big;
  wire logic              dp_fifo;
  wire logic [ADDR_W-1:0] next_addr;
  wire logic              next_big;
  wire logic              next_fifo;

  // Effective access target
  wire logic [ADDR_W-1:0] cur_addr;
  wire logic              cur_big;
  wire logic              cur_fifo;

  // Data path
  cycle_t            state;
  cycle_t            next_state;
  logic [2:0]        wr_cnt;
  logic [2:0]        rd_cnt;
  logic [WORD_W-1:0] asm_word;
  logic              write_armed;
  wire logic [2:0]   beats;
  wire logic         last_wr;
  wire logic         last_rd;
  wire logic         wr_take;
  wire logic [WORD_W-1:0] place_data;
  wire logic [3:0]        place_mask;
  wire logic [PIN_W-1:0]  pick_data;
  wire logic [WORD_W-1:0] lane_mask;
  wire logic [WORD_W-1:0] next_asm;
  wire logic [1:0]        drive_oe_n;

  assign sync_d = {cfg, cs_in, rd_or_dir_in, wr_or_access_enable_in,
                   address_latch_low_strobe, address_latch_high_strobe,
                   ad_in, low_addr_in, fifo_sel_in, cfg_big_endian};

  sync2 #(.W(SW)) u_sync (
    .clk   (clk),
    .d     (sync_d),
    .q     (sync_q)
  );

  assign {cs_cfg, cs_raw, rd_raw, wr_raw, lo_raw, hi_raw,
          ad_s, low_s, fsel_s, cbig_s} = sync_q;

  assign cs_act = ~(cs_raw ^ cs_cfg.cs_high);
  assign rd_lvl = ~(rd_raw ^ cs_cfg.rd_high);
  assign wr_lvl = ~(wr_raw ^ cs_cfg.wr_high);
  assign lo_act = ~(lo_raw ^ cs_cfg.lo_high);
  assign hi_act = ~(hi_raw ^ cs_cfg.hi_high);

  // Enable mode: direction active means read
  assign rd_cyc = cs_cfg.en_dir ? (cs_act & wr_lvl & rd_lvl)
                                : (cs_act & rd_lvl);
  assign wr_cyc = cs_cfg.en_dir ? (cs_act & wr_lvl & ~rd_lvl)
                                : (cs_act & wr_lvl);

  assign rd_start = rd_cyc & ~rd_prev;
  assign rd_end   = rd_prev & ~rd_cyc;
  assign wr_end   = wr_prev & ~wr_cyc;

  // Qualification looks at chip select while the strobe was still active
  assign lo_ok = ~cs_cfg.cs_qual | cs_prev;
  assign hi_ok = ~cs_cfg.cs_qual | cs_prev;

  assign take_sp  = ~cs_cfg.indexed & ~cs_cfg.dual_phase
                    & lo_prev & ~lo_act & lo_ok;
  assign take_dlo = ~cs_cfg.indexed & cs_cfg.dual_phase
                    & lo_prev & ~lo_act & lo_ok;
  assign take_dhi = ~cs_cfg.indexed & cs_cfg.dual_phase
                    & hi_prev & ~hi_act & hi_ok;

  // Single phase: pins 0 to 11 (0 to 10 in 16-bit), upper pins unused; 16-bit shifts by one word bit
  assign sp_addr = cs_cfg.bus16 ? {ad_prev[8:0], 1'b0}
                                : ad_prev[ADDR_W-1:0];
  assign sp_big  = cs_cfg.bus16 ? ad_prev[SP16_BIG] : ad_prev[SP8_BIG];
  assign sp_fifo = cs_cfg.bus16 ? ad_prev[SP16_FIFO]
                                : ad_prev[SP8_FIFO];

  // Dual phase: only the low eight pins carry address
  assign lo_addr  = cs_cfg.bus16 ? {addr[9], ad_prev[7:0], 1'b0}
                                 : {addr[9:8], ad_prev[7:0]};
  assign dlo_addr = take_dlo ? lo_addr : addr;
  assign hi_addr  = cs_cfg.bus16 ? {ad_prev[0], dlo_addr[8:0]}
                                 : {ad_prev[1:0], dlo_addr[7:0]};
  assign dp_big   = cs_cfg.bus16 ? ad_prev[DP16_BIG] : ad_prev[DP8_BIG];
  assign dp_fifo  = cs_cfg.bus16 ? ad_prev[DP16_FIFO]
                                 : ad_prev[DP8_FIFO];

  // Strobes may come in either order, or in the same cycle
  assign next_addr = take_sp  ? sp_addr :
                     take_dhi ? hi_addr : dlo_addr;
  assign next_big  = take_sp  ? sp_big  :
                     take_dhi ? dp_big  : big;
  assign next_fifo = take_sp  ? sp_fifo :
                     take_dhi ? dp_fifo : fifo;

  // Indexed mode: upper bits from the index, low bits straight from pins (bit 0 forced low in 16-bit)
  assign cur_addr = cs_cfg.indexed
                    ? {index_dword, low_s[1], low_s[0] & ~cs_cfg.bus16}
                    : addr;
  assign cur_big  = cs_cfg.indexed ? cbig_s : big;
  assign cur_fifo = cs_cfg.indexed ? fsel_s : fifo;

  assign beats   = cs_cfg.bus16 ? BEATS_16 : BEATS_8;
  assign last_wr = (wr_cnt == beats - 3'h1);
  assign last_rd = (rd_cnt == beats - 3'h1);
  // Writes after reset are dropped until the host has read once
  assign wr_take = wr_end & write_armed;

  byte_lanes u_lanes (
    .off        (cur_addr[1:0]),
    .w16        (cs_cfg.bus16),
    .big        (cur_big),
    .host_data  (ad_prev),
    .word_in    (rdata),
    .place_data (place_data),
    .place_mask (place_mask),
    .pick_data  (pick_data)
  );

  assign lane_mask = expand_mask(place_mask);
  assign next_asm  = (asm_word & ~lane_mask)
                     | (place_data & lane_mask);

  // Upper pins stay released whenever the bus is 8 bits wide
  assign drive_oe_n = {~cs_cfg.bus16, 1'b0};

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (rd_start) begin
          next_state = ST_READ;
        end else if (wr_cyc) begin
          next_state = ST_WRITE;
        end
      end
      ST_READ: begin
        if (!rd_cyc) begin
          next_state = ST_IDLE;
        end
      end
      ST_WRITE: begin
        if (!wr_cyc) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cs_prev <= 1'b0;
      rd_prev <= 1'b0;
      wr_prev <= 1'b0;
      lo_prev <= 1'b0;
      hi_prev <= 1'b0;
      ad_prev <= RST_PINS;
    end else begin
      cs_prev <= cs_act;
      rd_prev <= rd_cyc;
      wr_prev <= wr_cyc;
      lo_prev <= lo_act;
      hi_prev <= hi_act;
      ad_prev <= ad_s;
    end
  end

  // Address survives any number of data cycles
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      addr <= RST_ADDR;
      big  <= 1'b0;
      fifo <= 1'b0;
    end else begin
      addr <= next_addr;
      big  <= next_big;
      fifo <= next_fifo;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state       <= ST_IDLE;
      write_armed <= 1'b0;
    end else begin
      state <= next_state;
      if (rd_end) begin
        write_armed <= 1'b1;
      end
    end
  end

  // Write beats fill lanes in any order; a count closes the word
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_cnt   <= 3'h0;
      asm_word <= RST_WORD;
    end else if (wr_take) begin
      asm_word <= next_asm;
      wr_cnt   <= last_wr ? 3'h0 : wr_cnt + 3'h1;
    end
  end

  // Read beats are only counted; repeats of a lane are not caught
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_cnt <= 3'h0;
    end else if (rd_end) begin
      rd_cnt <= last_rd ? 3'h0 : rd_cnt + 3'h1;
    end
  end

  // Data is picked when the read opens so live bits hold still
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ad_out     <= RST_PINS;
      ad_oe_n    <= OE_OFF;
      read_begin <= 1'b0;
    end else begin
      read_begin <= rd_start;
      if (rd_start) begin
        ad_out  <= pick_data;
        ad_oe_n <= drive_oe_n;
      end else if (next_state != ST_READ) begin
        ad_oe_n <= OE_OFF;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      int_req <= '0;
    end else begin
      int_req.addr    <= cur_addr;
      int_req.big     <= cur_big;
      int_req.fifo    <= cur_fifo;
      int_req.wr      <= wr_take & last_wr;
      int_req.rd_done <= rd_end & last_rd;
      if (wr_take && last_wr) begin
        int_req.wdata <= next_asm;
      end
    end
  end

endmodule
`default_nettype wire

// file: host_bus_sva.sv
`timescale 1ns/10ps
`default_nettype none
module host_bus_sva
  import host_bus_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  var  host_cfg_t  cfg,
  input  wire logic       address_latch_low_strobe,
  input  wire logic       address_latch_high_strobe,
  input  wire logic [1:0] ad_oe_n,
  input  wire logic       read_begin,
  input  var  int_req_t   int_req
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_reset_quiet: assert property (disable iff (1'b0) !rst_n |=>
    ad_oe_n == OE_OFF && !int_req.wr && !read_begin && int_req.addr == RST_ADDR)
    else $error("outputs not quiet after reset");
  a_wr_one_cycle: assert property (int_req.wr |=> !int_req.wr)
    else $error("word write pulse too long");
  a_rd_done_pulse: assert property (int_req.rd_done |=> !int_req.rd_done)
    else $error("read done pulse too long");
  a_begin_pulse: assert property (read_begin |=> !read_begin)
    else $error("read begin pulse too long");
  a_drive_on_read: assert property (read_begin |-> ##[0:1] !ad_oe_n[0])
    else $error("low lane not driven on read");
  a_upper_never_driven: assert property (!cfg.bus16 |-> ad_oe_n[1])
    else $error("upper lane driven in 8-bit mode");
  // Six quiet strobe cycles cover the four-cycle latch latency
  a_addr_held: assert property ((!cfg.indexed && $stable(address_latch_low_strobe) &&
    $stable(address_latch_high_strobe))[*6] |-> $stable(int_req.addr))
    else $error("address moved without a latch strobe");
  a_wr_bus_free: assert property (int_req.wr |-> ad_oe_n == OE_OFF)
    else $error("word write while pins driven");
endmodule

bind host_bus_unit host_bus_sva host_bus_sva_i (.clk(clk), .rst_n(rst_n), .cfg(cfg),
  .address_latch_low_strobe(address_latch_low_strobe),
  .address_latch_high_strobe(address_latch_high_strobe),
  .ad_oe_n(ad_oe_n), .read_begin(read_begin), .int_req(int_req));
`default_nettype wire

// file: host_model.sv
`timescale 1ns/10ps
`default_nettype none
module host_model
  import host_bus_pkg::*;
(
  input  wire logic             clk,
  input  var  host_cfg_t        cfg,
  input  wire logic [PIN_W-1:0] ad_out,
  input  wire logic [1:0]       ad_oe_n,
  output var  logic             cs,
  output var  logic             rd,
  output var  logic             wr,
  output var  logic             lo,
  output var  logic             hi,
  output var  logic [PIN_W-1:0] ad
);
  logic [PIN_W-1:0] drv;

  // Pin level: a lane the device enables carries its data
  assign ad = {ad_oe_n[1] ? drv[15:8] : ad_out[15:8], ad_oe_n[0] ? drv[7:0] : ad_out[7:0]};

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic idle();
    cs = ~cfg.cs_high;
    rd = ~cfg.rd_high;
    wr = ~cfg.wr_high;
    lo = ~cfg.lo_high;
    hi = ~cfg.hi_high;
    drv = RST_PINS;
  endtask

  task automatic latch(input logic high, input logic sel, input logic [PIN_W-1:0] a);
    drv = a;
    cs = sel ? cfg.cs_high : ~cfg.cs_high;
    step(2);
    if (high) begin
      hi = cfg.hi_high;
    end else begin
      lo = cfg.lo_high;
    end
    step(4);
    hi = ~cfg.hi_high;
    lo = ~cfg.lo_high;
    step(2);
    cs = ~cfg.cs_high;
    // Released lines flip so a stale value cannot pass
    drv = ~a;
    step(4);
  endtask

  task automatic write(input logic [PIN_W-1:0] d);
    drv = d;
    cs = cfg.cs_high;
    wr = cfg.wr_high;
    step(4);
    wr = ~cfg.wr_high;
    cs = ~cfg.cs_high;
    step(2);
    drv = ~d;
    step(4);
  endtask

  task automatic read(output logic [PIN_W+1:0] got);
    drv = ~drv;
    cs = cfg.cs_high;
    rd = cfg.rd_high;
    wr = cfg.en_dir ? cfg.wr_high : ~cfg.wr_high;
    step(6);
    got = {ad_oe_n, ad};
    rd = ~cfg.rd_high;
    wr = ~cfg.wr_high;
    cs = ~cfg.cs_high;
    step(6);
  endtask
endmodule
`default_nettype wire

// file: testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench
  import host_bus_pkg::*;
;
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  host_cfg_t         cfg;
  logic              cs, rd, wr, lo, hi, read_begin;
  logic [PIN_W-1:0]  ad_in, ad_out;
  logic [1:0]        ad_oe_n;
  logic [WORD_W-1:0] rdata, wr_word;
  logic [PIN_W+1:0]  got;
  int_req_t          int_req;
  logic [1:0]        low_addr = 2'h0;
  logic              fifo_sel = 1'b0;
  logic              big_sel = 1'b0;
  logic [IDX_W-1:0]  dword_idx = 8'h00;
  logic              wr_fifo;
  int                n_wr = 0, n_rd = 0, n_mismatch = 0, cmp_count = 0;

  always #5 clk = ~clk;

  host_bus_unit host_bus_unit_i (.clk(clk), .rst_n(rst_n), .cfg(cfg), .cs_in(cs),
    .rd_or_dir_in(rd), .wr_or_access_enable_in(wr), .address_latch_low_strobe(lo),
    .address_latch_high_strobe(hi), .ad_in(ad_in), .low_addr_in(low_addr),
    .fifo_sel_in(fifo_sel), .cfg_big_endian(big_sel), .index_dword(dword_idx),
    .rdata(rdata), .ad_out(ad_out),
    .ad_oe_n(ad_oe_n), .read_begin(read_begin), .int_req(int_req));

  host_model host_model_i (.clk(clk), .cfg(cfg), .ad_out(ad_out), .ad_oe_n(ad_oe_n),
    .cs(cs), .rd(rd), .wr(wr), .lo(lo), .hi(hi), .ad(ad_in));

  always @(posedge clk) begin
    if (int_req.wr === 1'b1) begin
      n_wr++;
      wr_word = int_req.wdata;
      wr_fifo = int_req.fifo;
    end
    if (int_req.rd_done === 1'b1) begin
      n_rd++;
    end
  end

  task automatic chk(input logic [WORD_W-1:0] g, input logic [WORD_W-1:0] e);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // Two edges flush the synchronisers with the new polarity
  task automatic do_reset(input host_cfg_t c);
    rst_n = 1'b0;
    cfg = c;
    host_model_i.idle();
    repeat (2) @(posedge clk);
    #1;
    rst_n = 1'b1;
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic finish_test();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    #100000;
    n_mismatch++;
    finish_test();
  end

  initial begin
    rdata = 32'hA1B2C3D4;
    do_reset(10'h100);
    chk(ad_oe_n, OE_OFF);
    host_model_i.latch(1'b0, 1'b1, 16'h0492);
    chk(int_req.addr, 10'h124);
    chk({int_req.fifo, int_req.big}, 2'h2);
    host_model_i.read(got);
    chk(got, {2'h0, 16'hC3D4});
    host_model_i.latch(1'b0, 1'b0, 16'h0493);
    host_model_i.read(got);
    chk(got, {2'h0, 16'hA1B2});
    chk(n_rd, 1);
    host_model_i.write(16'h1234);
    host_model_i.latch(1'b0, 1'b1, 16'h0492);
    host_model_i.write(16'h5678);
    chk(n_wr, 1);
    chk(wr_word, 32'h12345678);
    chk(int_req.fifo, 1'b1);
    chk(int_req.addr, 10'h124);
    do_reset(10'h0BF);
    chk(int_req.addr, RST_ADDR);
    host_model_i.latch(1'b1, 1'b1, 16'h0006);
    host_model_i.latch(1'b0, 1'b0, 16'h00FF);
    host_model_i.latch(1'b0, 1'b1, 16'h0055);
    chk(int_req.addr, 10'h255);
    chk({int_req.fifo, int_req.big}, 2'h1);
    host_model_i.read(got);
    chk({got[17:16], got[7:0]}, {2'h2, 8'hB2});
    low_addr = 2'h3;
    fifo_sel = 1'b1;
    dword_idx = 8'h5A;
    do_reset(10'h240);
    chk(int_req.addr, 10'h16B);
    host_model_i.read(got);
    chk({got[17:16], got[7:0]}, {2'h2, 8'hA1});
    low_addr = 2'h0;
    host_model_i.read(got);
    chk({got[17:16], got[7:0]}, {2'h2, 8'hD4});
    big_sel = 1'b1;
    low_addr = 2'h1;
    host_model_i.read(got);
    chk({got[17:16], got[7:0]}, {2'h2, 8'hB2});
    big_sel = 1'b0;
    for (int i = 0; i < 4; i++) begin
      low_addr = 2'(i);
      host_model_i.write({8'h00, 8'(8'h11 * (i + 1))});
    end
    chk(n_wr, 2);
    chk(wr_word, 32'h44332211);
    chk(wr_fifo, 1'b1);
    finish_test();
  end
endmodule
`default_nettype wire
